// ==== inc/swm_pkg.sv ====
package swm_pkg;

    // ======================================================================
    // Window placement and register offsets
    // ======================================================================
    localparam logic [15:0] WINDOW_OFFSET    = 16'h0060;
    localparam int          WINDOW_BYTES     = 32;
    localparam logic [4:0]  OFF_RELOAD       = 5'h00;
    localparam logic [4:0]  OFF_INIT_VALUE   = 5'h01;
    localparam logic [4:0]  OFF_MBOX_IN      = 5'h02;
    localparam logic [4:0]  OFF_MBOX_OUT     = 5'h03;
    localparam logic [4:0]  OFF_STATUS_ONE   = 5'h04;
    localparam logic [4:0]  OFF_STATUS_TWO   = 5'h06;
    localparam logic [4:0]  OFF_CONTROL_ONE  = 5'h08;
    localparam logic [4:0]  OFF_CONTROL_TWO  = 5'h0a;
    localparam logic [4:0]  OFF_MESSAGE      = 5'h0c;
    localparam logic [4:0]  OFF_WD_STATUS    = 5'h0e;
    localparam logic [4:0]  OFF_SW_IRQ       = 5'h10;

    // ======================================================================
    // Reset values and field positions
    // ======================================================================
    localparam logic [5:0]  RST_COUNT        = 6'h00;
    localparam logic [5:0]  RST_INIT_VALUE   = 6'h04;
    localparam logic [5:0]  MIN_INIT_VALUE   = 6'h04;
    localparam logic [7:0]  RST_BYTE         = 8'h00;
    localparam int          BIT_TIMEOUT_FLAG = 3;
    localparam int          BIT_OS_FLAG      = 1;
    localparam int          BIT_REPLY_FLAG   = 2;
    localparam int          SEL_LSB          = 0;

    // Interrupt-select codes for the outbound mailbox.
    typedef enum logic [1:0] {
        SEL_IRQ  = 2'b00,
        SEL_SCI  = 2'b01,
        SEL_MGMT = 2'b10,
        SEL_NONE = 2'b11
    } swm_sel_type;

    // ======================================================================
    // Timing
    // ======================================================================
    localparam int          TICK_PERIOD_MS   = 600;
    localparam int          CLK_HZ           = 20_000_000;
    localparam int          TICK_CYCLES      =
        (CLK_HZ / 1000) * TICK_PERIOD_MS;

endpackage

// ==== hw/swm_tick_gen.sv ====
`timescale 1ns/100ps
module swm_tick_gen
    import swm_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Restart of the tick phase
    input  wire logic restart,
    // One-cycle tick
    output logic      tick
);

    logic [31:0] count;

    // ======================================================================
    // Divider
    // ======================================================================
    // Restarting the phase on reload makes every period a full tick long.
    always_ff @(posedge clk) begin
        if (rst || restart) begin
            count <= 32'h0000_0000;
            tick  <= 1'b0;
        end else if (count == 32'(TICK_CYCLES_P - 1)) begin
            count <= 32'h0000_0000;
            tick  <= 1'b1;
        end else begin
            count <= count + 32'h0000_0001;
            tick  <= 1'b0;
        end
    end

endmodule

// ==== hw/swm_top.sv ====
`timescale 1ns/100ps
module swm_top
    import swm_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Window placement
    input  wire logic [15:0] power_mgmt_base,
    // I/O access port
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic [7:0]       io_rdata,
    output logic             io_hit,
    // Events
    output logic             system_management_interrupt,
    output logic             sci_pulse,
    output logic             irq_pulse,
    output logic             timeout_pulse
);

    // ======================================================================
    // Decode
    // ======================================================================
    logic [15:0] watchdog_window_base;
    logic [4:0]  offs;
    logic [15:0] rel_addr;
    logic        wr_hit;
    logic        rd_hit;
    logic        tick;
    logic        reload_wr;

    function automatic logic in_window(input logic [15:0] a,
                                       input logic [15:0] b);
        logic [15:0] d;
        d = a - b;
        return d < 16'(WINDOW_BYTES);
    endfunction

    function automatic logic wr_at(input logic       w,
                                   input logic [4:0] o,
                                   input logic [4:0] r);
        return w && (o == r);
    endfunction

    assign watchdog_window_base = power_mgmt_base + WINDOW_OFFSET;
    // The window base need not be 32-byte aligned, so the offset is taken
    // from the distance to the base and not from the low address bits.
    assign rel_addr = io_addr - watchdog_window_base;
    assign offs     = rel_addr[4:0];
    assign wr_hit = io_wr && in_window(io_addr, watchdog_window_base);
    assign rd_hit = io_rd && in_window(io_addr, watchdog_window_base);
    assign reload_wr = wr_at(wr_hit, offs, OFF_RELOAD);

    // ======================================================================
    // Storage
    // ======================================================================
    logic [5:0]  count;
    logic [5:0]  init_value;
    logic [7:0]  os_to_handler_mailbox;
    logic [7:0]  handler_to_os_mailbox;
    logic [15:0] mgmt_status_one;
    logic [15:0] mgmt_status_two;
    logic [15:0] mgmt_control_one;
    logic [15:0] mgmt_control_two;
    logic [15:0] boot_progress_message;
    logic [7:0]  watchdog_status_byte;
    logic [7:0]  software_irq_generate;
    logic        expire;
    logic        mbox_in_wr;
    logic        mbox_out_wr;
    swm_sel_type interrupt_select_setting;

    assign mbox_in_wr  = wr_at(wr_hit, offs, OFF_MBOX_IN);
    assign mbox_out_wr = wr_at(wr_hit, offs, OFF_MBOX_OUT);
    assign expire      = tick && (count == RST_COUNT) && !reload_wr;
    assign interrupt_select_setting =
        swm_sel_type'(mgmt_control_two[SEL_LSB +: 2]);

    swm_tick_gen #(
        .TICK_CYCLES_P (TICK_CYCLES_P)
    ) swm_tick_gen_i (
        .clk     (clk),
        .rst     (rst),
        .restart (reload_wr),
        .tick    (tick)
    );

    // ======================================================================
    // Watchdog countdown
    // ======================================================================
    // A write of 0 to 3 keeps the previous start value, so the shortest period
    // after a reload or an expiry can never fall below five ticks.
    always_ff @(posedge clk) begin
        if (rst) begin
            init_value <= RST_INIT_VALUE;
        end else if (wr_at(wr_hit, offs, OFF_INIT_VALUE) &&
                     io_wdata[5:0] >= MIN_INIT_VALUE) begin
            init_value <= io_wdata[5:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count <= RST_COUNT;
        end else if (reload_wr) begin
            count <= init_value;
        end else if (expire) begin
            count <= init_value;
        end else if (tick) begin
            count <= count - 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            timeout_pulse <= 1'b0;
        end else begin
            timeout_pulse <= expire;
        end
    end

    // ======================================================================
    // Mailboxes
    // ======================================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            os_to_handler_mailbox <= RST_BYTE;
        end else if (mbox_in_wr) begin
            os_to_handler_mailbox <= io_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            handler_to_os_mailbox <= RST_BYTE;
        end else if (mbox_out_wr) begin
            handler_to_os_mailbox <= io_wdata;
        end
    end

    // An inbound write and an outbound write with SEL_MGMT never fall in one
    // cycle; the shared output simply ORs the two requests into one pulse.
    always_ff @(posedge clk) begin
        if (rst) begin
            system_management_interrupt <= 1'b0;
            sci_pulse                   <= 1'b0;
            irq_pulse                   <= 1'b0;
        end else begin
            system_management_interrupt <= mbox_in_wr ||
                (mbox_out_wr &&
                 interrupt_select_setting == SEL_MGMT);
            sci_pulse <= mbox_out_wr &&
                interrupt_select_setting == SEL_SCI;
            irq_pulse <= mbox_out_wr &&
                interrupt_select_setting == SEL_IRQ;
        end
    end

    // ======================================================================
    // Status: write one to clear, a setting event wins over the clear
    // ======================================================================
    logic [15:0] next_status_one;
    logic [15:0] clr_mask;
    logic [15:0] set_mask;

    always_comb begin
        clr_mask = 16'h0000;
        set_mask = 16'h0000;
        if (wr_at(wr_hit, offs, OFF_STATUS_ONE)) begin
            clr_mask[7:0] = io_wdata;
        end
        if (wr_at(wr_hit, offs, OFF_STATUS_ONE + 5'h01)) begin
            clr_mask[15:8] = io_wdata;
        end
        set_mask[BIT_OS_FLAG]      = mbox_in_wr;
        set_mask[BIT_REPLY_FLAG]   = mbox_out_wr;
        set_mask[BIT_TIMEOUT_FLAG] = expire;
        next_status_one = (mgmt_status_one & ~clr_mask) | set_mask;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mgmt_status_one <= 16'h0000;
        end else begin
            mgmt_status_one <= next_status_one;
        end
    end

    // ======================================================================
    // Plain storage registers
    // ======================================================================
    function automatic logic [15:0] wr16(input logic [15:0] cur,
                                         input logic [4:0]  base,
                                         input logic [4:0]  o,
                                         input logic        w,
                                         input logic [7:0]  d);
        logic [15:0] r;
        r = cur;
        if (w && o == base) begin
            r[7:0] = d;
        end
        if (w && o == base + 5'h01) begin
            r[15:8] = d;
        end
        return r;
    endfunction

    always_ff @(posedge clk) begin
        if (rst) begin
            mgmt_status_two       <= 16'h0000;
            mgmt_control_one      <= 16'h0000;
            mgmt_control_two      <= 16'h0000;
            boot_progress_message <= 16'h0000;
        end else begin
            mgmt_status_two <= wr16(mgmt_status_two, OFF_STATUS_TWO,
                                    offs, wr_hit, io_wdata);
            mgmt_control_one <= wr16(mgmt_control_one, OFF_CONTROL_ONE,
                                     offs, wr_hit, io_wdata);
            mgmt_control_two <= wr16(mgmt_control_two, OFF_CONTROL_TWO,
                                     offs, wr_hit, io_wdata);
            boot_progress_message <= wr16(boot_progress_message,
                                          OFF_MESSAGE, offs, wr_hit,
                                          io_wdata);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            watchdog_status_byte  <= RST_BYTE;
            software_irq_generate <= RST_BYTE;
        end else begin
            if (wr_at(wr_hit, offs, OFF_WD_STATUS)) begin
                watchdog_status_byte <= io_wdata;
            end
            if (wr_at(wr_hit, offs, OFF_SW_IRQ)) begin
                software_irq_generate <= io_wdata;
            end
        end
    end

    // ======================================================================
    // Read path
    // ======================================================================
    logic [7:0] next_rdata;

    always_comb begin
        unique case (offs)
            OFF_RELOAD:            next_rdata = {2'b00, count};
            OFF_INIT_VALUE:        next_rdata = {2'b00, init_value};
            OFF_MBOX_IN:           next_rdata = os_to_handler_mailbox;
            OFF_MBOX_OUT:          next_rdata = handler_to_os_mailbox;
            OFF_STATUS_ONE:        next_rdata = mgmt_status_one[7:0];
            OFF_STATUS_ONE + 5'h1: next_rdata = mgmt_status_one[15:8];
            OFF_STATUS_TWO:        next_rdata = mgmt_status_two[7:0];
            OFF_STATUS_TWO + 5'h1: next_rdata = mgmt_status_two[15:8];
            OFF_CONTROL_ONE:       next_rdata = mgmt_control_one[7:0];
            OFF_CONTROL_ONE + 5'h1: next_rdata = mgmt_control_one[15:8];
            OFF_CONTROL_TWO:       next_rdata = mgmt_control_two[7:0];
            OFF_CONTROL_TWO + 5'h1: next_rdata = mgmt_control_two[15:8];
            OFF_MESSAGE:           next_rdata = boot_progress_message[7:0];
            OFF_MESSAGE + 5'h1:    next_rdata = boot_progress_message[15:8];
            OFF_WD_STATUS:         next_rdata = watchdog_status_byte;
            OFF_SW_IRQ:            next_rdata = software_irq_generate;
            default:               next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            io_rdata <= 8'h00;
            io_hit   <= 1'b0;
        end else begin
            io_rdata <= rd_hit ? next_rdata : 8'h00;
            io_hit   <= rd_hit || wr_hit;
        end
    end

endmodule

// ==== dv/swm_top_properties.sv ====
`timescale 1ns/100ps
// ==========================================================================
// Port checker
// ==========================================================================
module swm_checker
    import swm_pkg::*;
#(
    parameter int TICK_CYCLES_P = TICK_CYCLES
) (
    // Clock, reset and placement
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [15:0] power_mgmt_base,
    // I/O access port
    input wire logic [15:0] io_addr,
    input wire logic        io_wr,
    input wire logic        io_rd,
    input wire logic [7:0]  io_wdata,
    input wire logic [7:0]  io_rdata,
    input wire logic        io_hit,
    // Events
    input wire logic        system_management_interrupt,
    input wire logic        sci_pulse,
    input wire logic        irq_pulse,
    input wire logic        timeout_pulse
);
    logic [15:0] rel;
    logic        out_q;
    logic        in_q;

    assign rel = io_addr - power_mgmt_base - WINDOW_OFFSET;

    // Remember which mailbox was written so each pulse has a known cause.
    always_ff @(posedge clk) begin
        out_q <= !rst && io_wr && rel == 16'h0003;
        in_q  <= !rst && io_wr && rel == 16'h0002;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_access;
        (io_wr || io_rd) && rel < 16'd32;
    endsequence
    sequence s_reload;
        io_wr && rel == 16'h0000;
    endsequence

    chk_hit_inside:
    assert property (s_access |=> io_hit)
        else $error("window access gave no hit");
    chk_hit_outside:
    assert property (!((io_wr || io_rd) && rel < 16'd32) |=> !io_hit)
        else $error("hit without window access");
    chk_count_top:
    assert property (io_rd && rel == 16'h0000 |=> io_rdata[7:6] == 2'b00)
        else $error("count read has upper bits set");
    chk_reload_quiet:
    assert property (s_reload |=> !timeout_pulse [*8])
        else $error("expiry right after reload");
    chk_in_mgmt_irq:
    assert property (io_wr && rel == 16'h0002 |=>
                     system_management_interrupt && io_hit)
        else $error("inbound write raised no interrupt");
    chk_out_onehot:
    assert property (io_wr && rel == 16'h0003 |=>
        $onehot0({irq_pulse, sci_pulse, system_management_interrupt}))
        else $error("outbound write raised several interrupts");
    chk_irq_cause:
    assert property (irq_pulse || sci_pulse |-> out_q)
        else $error("interrupt pulse without outbound write");
    chk_mgmt_cause:
    assert property (system_management_interrupt |-> in_q || out_q)
        else $error("management interrupt without mailbox write");
    chk_expiry_gap:
    assert property (timeout_pulse |=> !timeout_pulse [*8])
        else $error("expiry pulses too close");
endmodule

bind swm_top swm_checker #(.TICK_CYCLES_P(TICK_CYCLES_P)) swm_checker_i (
    .clk(clk), .rst(rst), .power_mgmt_base(power_mgmt_base),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_hit(io_hit),
    .system_management_interrupt(system_management_interrupt),
    .sci_pulse(sci_pulse), .irq_pulse(irq_pulse),
    .timeout_pulse(timeout_pulse));

// ==== dv/swm_top_tb.sv ====
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module swm_top_tb
    import swm_pkg::*;
;
    // A short tick keeps the whole countdown inside a brief run.
    localparam int T = 20;
    localparam logic [4:0] PLAIN [8] = '{5'h06, 5'h07, 5'h08, 5'h09,
                                         5'h0c, 5'h0d, 5'h0e, 5'h10};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] base = 16'h0000;
    logic [15:0] addr = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  rdata;
    logic        hit, mgi, sci, irq, tmo;
    logic [7:0]  q, cur, d;
    logic        h, seen;
    logic [2:0]  ev;
    logic [31:0] seed = 32'd10;
    int          failures = 0;
    int          n_tests = 0;
    int          n;

    swm_top #(.TICK_CYCLES_P(T)) swm_top_i (
        .clk(clk), .rst(rst), .power_mgmt_base(base), .io_addr(addr),
        .io_wr(wr), .io_rd(rd), .io_wdata(wdata), .io_rdata(rdata),
        .io_hit(hit), .system_management_interrupt(mgi), .sci_pulse(sci),
        .irq_pulse(irq), .timeout_pulse(tmo));

    always #25 clk = ~clk;

    // ======================================================================
    // Helpers
    // ======================================================================
    function logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    function automatic logic [2:0] sel_ev(input logic [1:0] s);
        return (s == 2'b11) ? 3'b000 : 3'b001 << s;
    endfunction
    function automatic logic [7:0] init_exp(input logic [7:0] o, v);
        return (v[5:0] < 6'd4) ? o : {2'b00, v[5:0]};
    endfunction
    function automatic logic [15:0] at(input logic [4:0] o);
        return base + WINDOW_OFFSET + {11'h000, o};
    endfunction
    // Outputs only stand for one cycle, so they are caught at once.
    task automatic acc(input logic w, input logic [15:0] a,
                       input logic [7:0] dv);
        @(negedge clk);
        addr = a;
        wr = w;
        rd = !w;
        wdata = dv;
        @(negedge clk);
        q = rdata;
        h = hit;
        ev = {mgi, sci, irq};
        wr = 1'b0;
        rd = 1'b0;
    endtask
    task automatic wr_r(input logic [4:0] o, input logic [7:0] dv);
        acc(1'b1, at(o), dv);
        `CHK(h, 1'b1)
    endtask
    task automatic rd_chk(input logic [4:0] o, input logic [7:0] e);
        acc(1'b0, at(o), 8'h00);
        `CHK(h, 1'b1)
        `CHK(q, e)
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        report_and_stop();
    end

    // ======================================================================
    // Scenarios
    // ======================================================================
    initial begin
        // An unaligned base checks that offsets follow the window base.
        base = {rnd(), rnd()};
        repeat (16) @(negedge clk);
        rst = 1'b0;
        rd_chk(OFF_RELOAD, 8'h00);
        rd_chk(OFF_INIT_VALUE, 8'h04);
        rd_chk(OFF_MBOX_IN, 8'h00);
        rd_chk(OFF_MBOX_OUT, 8'h00);
        foreach (PLAIN[i]) begin
            d = rnd();
            rd_chk(PLAIN[i], 8'h00);
            wr_r(PLAIN[i], d);
            rd_chk(PLAIN[i], d);
        end
        acc(1'b1, base + 16'h005f, 8'hff);
        `CHK(h, 1'b0)
        acc(1'b0, base + 16'h0080, 8'h00);
        `CHK(h, 1'b0)
        wr_r(5'h0f, 8'hff);
        rd_chk(5'h0f, 8'h00);
        rd_chk(5'h1f, 8'h00);
        cur = 8'h04;
        foreach (PLAIN[i]) begin
            d = (i == 0) ? 8'hff : (i == 1) ? 8'hc3 : rnd();
            wr_r(OFF_INIT_VALUE, d);
            cur = init_exp(cur, d);
            rd_chk(OFF_INIT_VALUE, cur);
        end
        d = rnd();
        d = {d[7:6], 5'b00010, d[0]};
        wr_r(OFF_INIT_VALUE, d);
        cur = init_exp(cur, d);
        wr_r(OFF_RELOAD, rnd());
        rd_chk(OFF_RELOAD, cur);
        repeat (2 * T + T / 2) @(negedge clk);
        rd_chk(OFF_RELOAD, cur - 8'd2);
        // Reloading just before expiry must keep the pulse away.
        seen = 1'b0;
        repeat (3) begin
            wr_r(OFF_RELOAD, rnd());
            repeat (cur * T) begin
                @(negedge clk);
                seen |= tmo;
            end
        end
        `CHK(seen, 1'b0)
        wr_r(OFF_RELOAD, rnd());
        n = 0;
        while (tmo !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        `CHK(n >= (cur + 1) * T - 1 && n <= (cur + 1) * T + 1, 1'b1)
        rd_chk(OFF_RELOAD, cur);
        acc(1'b0, at(OFF_STATUS_ONE), 8'h00);
        `CHK(q[3], 1'b1)
        d = rnd();
        wr_r(OFF_MBOX_IN, d);
        `CHK(ev, 3'b100)
        rd_chk(OFF_MBOX_IN, d);
        acc(1'b0, at(OFF_STATUS_ONE), 8'h00);
        `CHK(q[1], 1'b1)
        for (int s = 0; s < 4; s++) begin
            wr_r(OFF_CONTROL_TWO, {6'h00, 2'(s)});
            d = rnd();
            wr_r(OFF_MBOX_OUT, d);
            `CHK(ev, sel_ev(2'(s)))
            rd_chk(OFF_MBOX_OUT, d);
            acc(1'b0, at(OFF_STATUS_ONE), 8'h00);
            `CHK(q[2], 1'b1)
            wr_r(OFF_STATUS_ONE, 8'h06);
            acc(1'b0, at(OFF_STATUS_ONE), 8'h00);
            `CHK(q[2:1], 2'b00)
        end
        // A reset in mid-run must bring back count, start value, control two and the outbound mailbox.
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        rd_chk(OFF_RELOAD, 8'h00);
        rd_chk(OFF_INIT_VALUE, 8'h04);
        rd_chk(OFF_CONTROL_TWO, 8'h00);
        rd_chk(OFF_MBOX_OUT, 8'h00);
        report_and_stop();
    end
endmodule
